// ---- core/ddr_init_pkg.sv ----
// Constants shared by the memory initialisation controller and its bank timers.
// Assumes a 200 MHz system clock and a command clock of half that rate.
package ddr_init_pkg;
	localparam int MCLK_MHZ = 200;
	localparam int CK_DIV = 2;
	localparam int STABLE_US = 200;
	// Least time, rounded up to whole command clocks
	localparam int STABLE_CYCLES = (STABLE_US * MCLK_MHZ + CK_DIV - 1) / CK_DIV;
	localparam int DUMMY_MRS = 2;
	localparam int INIT_REFS = 8;
	localparam int INIT_NOPS = 1024;
	localparam int DLL_LOCK_CYCLES = 1024;
	localparam int MRSC_CYCLES = 6;
	localparam int RC_CYCLES = 4;
	localparam int BANKS = 8;
	localparam int BANK_W = 3;
	localparam int ADDR_W = 20;
	localparam int WAIT_W = 16;
	localparam int DLL_W = 11;
	localparam int RC_W = 8;
	localparam int DLL_BIT = 7;
	localparam logic [ADDR_W-1:0] UPPER_MASK = 20'h3FC00;
	localparam logic [ADDR_W-1:0] DLL_MASK = 20'h00080;
	// Command pins {select_n, write_n, refresh_n}
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_WRITE = 3'h1;
	localparam logic [2:0] CMD_AUTO_REFRESH_CMD = 3'h2;
	localparam logic [2:0] CMD_READ = 3'h3;
	localparam logic [1:0] REQ_READ = 2'h0;
	localparam logic [1:0] REQ_WRITE = 2'h1;
	localparam logic [1:0] REQ_AUTO_REFRESH_CMD = 2'h2;
	typedef enum logic [3:0] {
		ST_STABLE,
		ST_MRS_DUMMY,
		ST_MRS_VALID,
		ST_MRSC,
		ST_INIT_REF,
		ST_READY,
		ST_DLL_OFF,
		ST_DLL_WAIT,
		ST_DLL_ON
	} ctrl_state_t;
endpackage : ddr_init_pkg

// ---- core/bank_timer_if.sv ----
// Links the controller to its per-bank busy timers.
// Assumes every timer shares the controller's clock.
`timescale 1ns/1ps
interface bank_timer_if #(
	parameter int BANKS = 8,
	parameter int CNT_W = 8
);
	logic tick;
	logic [BANKS-1:0] start;
	logic [CNT_W-1:0] load;
	logic [BANKS-1:0] busy;
	modport ctrl (output tick, output start, output load, input busy);
	modport timer (input tick, input start, input load, output busy);
endinterface : bank_timer_if

// ---- core/bank_timer.sv ----
// One bank's row cycle timer: busy while a new command would be too early.
// Ignores start unless tick is high in the same cycle.
`timescale 1ns/1ps
module bank_timer #(
	parameter int IDX = 0,
	parameter int CNT_W = 8
)(
	input wire logic mclk,
	input wire logic sys_rst,
	bank_timer_if.timer tif
);
	logic [CNT_W-1:0] cnt;

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			cnt <= '0;
		else if (tif.tick && tif.start[IDX])
			cnt <= tif.load;
		else if (tif.tick && cnt != '0)
			cnt <= cnt - 1'b1;
	end

	assign tif.busy[IDX] = (cnt != '0);
endmodule : bank_timer

// ---- core/ddr_init_ctrl.sv ----
// Controller for the memory's command pins: power-up sequence, DLL reset
// and per-bank spacing of user commands.
// Assumes user inputs are synchronous to mclk; pins feed the memory only.
`timescale 1ns/1ps

// Contract
// - Hold no-operation on the command pins for 200 us before any command.
// - Issue at least three back-to-back mode register sets, dummies then the valid one.
// - No mode set recovery gap is needed within that first burst.
// - Drive all address pins low during the dummy mode register sets.
// - After recovery time, refresh all 8 banks among 1,024 no-operations before use.
// - The eight refreshes may sit anywhere among the 1,024 no-operations.
// - Keep row cycle time between a refresh and the next command to that bank.
// - Spacing the initial refreshes 2,048 no-operations apart is not needed.
// - Hold address bits 10 to 17 low during initial mode register sets.
// - Reset the DLL through the mode register after a clock or supply change.
// - Writes may go back to back, but same-bank writes wait row cycle time.
// - Reads may go back to back, but same-bank reads wait row cycle time.
// - Keep the true and inverted clock at distinct levels at all times.
// - Wait 1,024 clocks after enabling the DLL before any read.
// - A refresh carries only the bank; other address pins are ignored.
module ddr_init_ctrl #(
	parameter int STABLE_CYCLES = ddr_init_pkg::STABLE_CYCLES,
	parameter int MRSC_CYCLES = ddr_init_pkg::MRSC_CYCLES,
	parameter int RC_CYCLES = ddr_init_pkg::RC_CYCLES
)(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [ddr_init_pkg::ADDR_W-1:0] mode_cfg,
	input wire logic dll_reset_req,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [1:0] req_kind,
	input wire logic [ddr_init_pkg::BANK_W-1:0] req_bank,
	input wire logic [ddr_init_pkg::ADDR_W-1:0] req_addr,
	output logic init_done,
	output logic mem_ck,
	output logic mem_ck_n,
	output logic mem_cs_n,
	output logic mem_we_n,
	output logic mem_ref_n,
	output logic [ddr_init_pkg::ADDR_W-1:0] mem_addr,
	output logic [ddr_init_pkg::BANK_W-1:0] mem_ba
);
	localparam int AW = ddr_init_pkg::ADDR_W;
	localparam int WW = ddr_init_pkg::WAIT_W;
	localparam int BW = ddr_init_pkg::BANK_W;

	ddr_init_pkg::ctrl_state_t st;
	ddr_init_pkg::ctrl_state_t next_st;
	logic [WW-1:0] wait_cnt;
	logic [WW-1:0] next_wait;
	logic [2:0] next_cmd;
	logic [AW-1:0] next_addr;
	logic [BW-1:0] next_ba;
	logic [ddr_init_pkg::BANKS-1:0] next_start;
	logic [ddr_init_pkg::DLL_W-1:0] dll_cnt;
	logic dll_pend;
	logic issue;
	logic tick;

	bank_timer_if #(.BANKS(ddr_init_pkg::BANKS), .CNT_W(ddr_init_pkg::RC_W)) tif ();

	////////////////////////////////////////////////////////////////////////////
	// Command clock

	// both clock pins from complementary flops, reset apart
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mem_ck <= 1'b0;
			mem_ck_n <= 1'b1;
		end
		else
		begin
			mem_ck <= ~mem_ck;
			mem_ck_n <= mem_ck;
		end
	end

	// Pins change as the command clock falls, a half period before it samples
	assign tick = mem_ck;

	////////////////////////////////////////////////////////////////////////////
	// Request acceptance and decode

	wire logic [AW-1:0] cfg_on = (mode_cfg & ~ddr_init_pkg::UPPER_MASK) | ddr_init_pkg::DLL_MASK;
	wire logic [AW-1:0] cfg_off = cfg_on & ~ddr_init_pkg::DLL_MASK;
	wire logic bank_free = ~tif.busy[req_bank];
	wire logic is_req_read = (req_kind == ddr_init_pkg::REQ_READ);
	wire logic is_req_auto_refresh_cmd = (req_kind == ddr_init_pkg::REQ_AUTO_REFRESH_CMD);
	wire logic kind_ok = (req_kind != 2'h3);
	// reads held off until the DLL has locked
	wire logic read_ok = ~is_req_read | (dll_cnt == '0);
	wire logic [2:0] req_cmd = is_req_read ? ddr_init_pkg::CMD_READ :
		is_req_auto_refresh_cmd ? ddr_init_pkg::CMD_AUTO_REFRESH_CMD : ddr_init_pkg::CMD_WRITE;
	// a busy bank stalls the requester
	assign req_ready = tick && (st == ddr_init_pkg::ST_READY) && !dll_pend && bank_free
		&& read_ok && kind_ok;
	wire logic accept = req_valid && req_ready;
	wire logic dll_on_issue = (st == ddr_init_pkg::ST_MRS_VALID) || (st == ddr_init_pkg::ST_DLL_ON);

	assign tif.tick = tick;
	assign tif.start = next_start;
	assign tif.load = ddr_init_pkg::RC_W'(RC_CYCLES - 1);

	for (genvar b = 0; b < ddr_init_pkg::BANKS; b++)
	begin : g_timer
		bank_timer #(.IDX(b), .CNT_W(ddr_init_pkg::RC_W)) u_timer (
			.mclk(mclk),
			.sys_rst(sys_rst),
			.tif(tif.timer)
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	always_comb
	begin
		next_st = st;
		next_wait = wait_cnt;
		next_cmd = ddr_init_pkg::CMD_NOP;
		next_addr = '0;
		next_ba = '0;
		next_start = '0;
		case (st)
			// idle until the stable period is over
			ddr_init_pkg::ST_STABLE:
			begin
				next_wait = wait_cnt + 1'b1;
				if (wait_cnt == WW'(STABLE_CYCLES - 1))
				begin
					next_st = ddr_init_pkg::ST_MRS_DUMMY;
					next_wait = '0;
				end
			end
			// dummies back to back, all address pins low
			ddr_init_pkg::ST_MRS_DUMMY:
			begin
				next_cmd = ddr_init_pkg::CMD_MRS;
				next_wait = wait_cnt + 1'b1;
				if (wait_cnt == WW'(ddr_init_pkg::DUMMY_MRS - 1))
				begin
					next_st = ddr_init_pkg::ST_MRS_VALID;
					next_wait = '0;
				end
			end
			// valid setting with upper bits cleared
			ddr_init_pkg::ST_MRS_VALID:
			begin
				next_cmd = ddr_init_pkg::CMD_MRS;
				next_addr = cfg_on;
				next_st = ddr_init_pkg::ST_MRSC;
			end
			ddr_init_pkg::ST_MRSC:
			begin
				next_wait = wait_cnt + 1'b1;
				if (wait_cnt == WW'(MRSC_CYCLES - 1))
				begin
					next_st = ddr_init_pkg::ST_INIT_REF;
					next_wait = '0;
				end
			end
			// one refresh per bank first, then the idle slots
			ddr_init_pkg::ST_INIT_REF:
			begin
				next_wait = wait_cnt + 1'b1;
				if (wait_cnt < WW'(ddr_init_pkg::INIT_REFS))
				begin
					next_cmd = ddr_init_pkg::CMD_AUTO_REFRESH_CMD;
					next_ba = wait_cnt[BW-1:0];
					next_start[wait_cnt[BW-1:0]] = 1'b1;
				end
				if (wait_cnt == WW'(ddr_init_pkg::INIT_REFS + ddr_init_pkg::INIT_NOPS - 1))
				begin
					next_st = ddr_init_pkg::ST_READY;
					next_wait = '0;
				end
			end
			ddr_init_pkg::ST_READY:
			begin
				if (dll_pend)
					next_st = ddr_init_pkg::ST_DLL_OFF;
				else if (accept)
				begin
					next_cmd = req_cmd;
					next_addr = is_req_auto_refresh_cmd ? '0 : req_addr;
					next_ba = req_bank;
					next_start[req_bank] = 1'b1;
				end
			end
			// DLL off, recovery, then DLL on again
			ddr_init_pkg::ST_DLL_OFF:
			begin
				next_cmd = ddr_init_pkg::CMD_MRS;
				next_addr = cfg_off;
				next_st = ddr_init_pkg::ST_DLL_WAIT;
				next_wait = '0;
			end
			ddr_init_pkg::ST_DLL_WAIT:
			begin
				next_wait = wait_cnt + 1'b1;
				if (wait_cnt == WW'(MRSC_CYCLES - 1))
					next_st = ddr_init_pkg::ST_DLL_ON;
			end
			ddr_init_pkg::ST_DLL_ON:
			begin
				next_cmd = ddr_init_pkg::CMD_MRS;
				next_addr = cfg_on;
				next_st = ddr_init_pkg::ST_READY;
				next_wait = '0;
			end
			default:
				next_st = ddr_init_pkg::ST_STABLE;
		endcase
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st <= ddr_init_pkg::ST_STABLE;
			wait_cnt <= '0;
			{mem_cs_n, mem_we_n, mem_ref_n} <= ddr_init_pkg::CMD_NOP;
			mem_addr <= '0;
			mem_ba <= '0;
			issue <= 1'b0;
		end
		else
		begin
			issue <= tick && (next_cmd != ddr_init_pkg::CMD_NOP);
			if (tick)
			begin
				st <= next_st;
				wait_cnt <= next_wait;
				{mem_cs_n, mem_we_n, mem_ref_n} <= next_cmd;
				mem_addr <= next_addr;
				mem_ba <= next_ba;
			end
		end
	end

	// lock countdown restarts on every DLL enable
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			dll_cnt <= '0;
		else if (tick && dll_on_issue)
			dll_cnt <= ddr_init_pkg::DLL_W'(ddr_init_pkg::DLL_LOCK_CYCLES);
		else if (tick && dll_cnt != '0)
			dll_cnt <= dll_cnt - 1'b1;
	end

	// A new request arriving as the old one is taken is kept
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			dll_pend <= 1'b0;
		else if (dll_reset_req)
			dll_pend <= 1'b1;
		else if (tick && st == ddr_init_pkg::ST_DLL_OFF)
			dll_pend <= 1'b0;
	end

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			init_done <= 1'b0;
		else if (st == ddr_init_pkg::ST_READY)
			init_done <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	localparam int DLL_GAP = 64;
	wire logic [2:0] pin_cmd = {mem_cs_n, mem_we_n, mem_ref_n};
	wire logic is_mrs = (pin_cmd == ddr_init_pkg::CMD_MRS);
	wire logic is_auto_refresh_cmd = (pin_cmd == ddr_init_pkg::CMD_AUTO_REFRESH_CMD);
	wire logic is_read = (pin_cmd == ddr_init_pkg::CMD_READ);
	wire logic bank_cmd = issue && !is_mrs;
	logic seen_cmd;
	logic [WW-1:0] pre_ticks;
	logic [WW-1:0] ref_ticks;
	logic [3:0] init_arefs;
	logic [11:0] dll_age;
	// Slots from the first refresh onwards, that refresh included
	wire logic ref_slot = (tick && init_arefs != '0) || (issue && is_auto_refresh_cmd && init_arefs == '0);

	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			seen_cmd <= 1'b0;
			pre_ticks <= '0;
			ref_ticks <= '0;
			init_arefs <= '0;
			dll_age <= '0;
		end
		else
		begin
			seen_cmd <= seen_cmd | issue;
			if (tick && !seen_cmd && pre_ticks != '1)
				pre_ticks <= pre_ticks + 1'b1;
			if (issue && is_auto_refresh_cmd && !init_done)
				init_arefs <= init_arefs + 1'b1;
			if (ref_slot && !init_done)
				ref_ticks <= ref_ticks + 1'b1;
			if (issue && is_mrs && mem_addr[ddr_init_pkg::DLL_BIT])
				dll_age <= '0;
			else if (dll_age != '1)
				dll_age <= dll_age + 1'b1;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence mrs_burst_s;
		(issue && is_mrs) ##2 (issue && is_mrs) ##2 (issue && is_mrs);
	endsequence
	sequence dummy_low_s;
		(mem_addr == '0) ##2 (mem_addr == '0);
	endsequence

	clock_apart_a: assert property (mem_ck != mem_ck_n)
		else $error("clock pins not complementary");
	stable_idle_a: assert property ((issue && !seen_cmd) |-> pre_ticks >= WW'(STABLE_CYCLES))
		else $error("command before stable period");
	mrs_burst_a: assert property ((issue && !seen_cmd) |-> mrs_burst_s)
		else $error("initial mode set burst broken");
	dummy_addr_a: assert property ((issue && !seen_cmd) |-> dummy_low_s)
		else $error("dummy mode set address not low");
	upper_addr_a: assert property ((issue && is_mrs)
		|-> (mem_addr & ddr_init_pkg::UPPER_MASK) == '0)
		else $error("upper address bits set in mode set");
	init_refresh_a: assert property ($rose(init_done) |-> init_arefs == 4'h8
		&& ref_ticks >= WW'(ddr_init_pkg::INIT_REFS + ddr_init_pkg::INIT_NOPS))
		else $error("initial refresh sequence incomplete");
	dll_read_a: assert property ((issue && is_read)
		|-> dll_age >= 12'(2 * ddr_init_pkg::DLL_LOCK_CYCLES))
		else $error("read before DLL lock");
	dll_reset_a: assert property ((issue && is_mrs && !mem_addr[ddr_init_pkg::DLL_BIT]
		&& init_done) |-> ##[2:DLL_GAP] (issue && is_mrs && mem_addr[ddr_init_pkg::DLL_BIT]))
		else $error("DLL not re-enabled after reset");

	for (genvar b = 0; b < ddr_init_pkg::BANKS; b++)
	begin : g_gap
		logic used;
		logic [7:0] gap;
		always_ff @(posedge mclk or posedge sys_rst)
		begin
			if (sys_rst)
			begin
				gap <= '0;
				used <= 1'b0;
			end
			else if (bank_cmd && mem_ba == BW'(b))
			begin
				gap <= '0;
				used <= 1'b1;
			end
			else if (gap != '1)
				gap <= gap + 1'b1;
		end
		bank_spacing_a: assert property ((bank_cmd && mem_ba == BW'(b) && used)
			|-> gap >= 8'(2 * RC_CYCLES - 1))
			else $error("same-bank command inside row cycle time");
	end
endmodule : ddr_init_ctrl

// ---- tb/mem_dev_model.sv ----
// Device-side model: decodes the command pins once per command clock,
// checks what the device demands of its controller and flags each command.
// Assumes pins change only on mclk edges where the command clock was high.
`timescale 1ns/1ps
module mem_dev_model #(
	parameter int STABLE_CYCLES = 10,
	parameter int MRSC_CYCLES = 6,
	parameter int RC_CYCLES = 4
)(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic mem_ck,
	input wire logic mem_ck_n,
	input wire logic [2:0] cmd,
	input wire logic [19:0] mem_addr,
	input wire logic [2:0] mem_ba,
	output logic ev_valid,
	output int dev_err
);
	int nops, mset_n, refs, slot, dll_slot, b;
	int last [8];
	logic go, mset;
	assign mset = cmd === ddr_init_pkg::CMD_MRS;
	////////////////////////////////////////////////////////////////
	always @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			{ev_valid, go} <= 2'b00;
			{dev_err, nops, mset_n, refs, slot, dll_slot} <= '0;
			for (int i = 0; i < 8; i++)
				last[i] <= -100;
		end
		else
		begin
			b = int'(mem_ck === mem_ck_n);
			ev_valid <= 1'b0;
			// Rising command clock: pins have stood one mclk already
			if (mem_ck === 1'b0)
			begin
				slot <= slot + 1;
				nops <= mset ? 0 : nops + int'(cmd === ddr_init_pkg::CMD_NOP);
				if (cmd !== ddr_init_pkg::CMD_NOP)
				begin
					ev_valid <= 1'b1;
					mset_n <= mset_n + int'(mset);
					if (mset_n < 3)
						b += int'(!mset || mem_addr[17:10] != 8'h00
							|| (mset_n < 2 && mem_addr != 20'h0)
							|| (mset_n == 0 ? nops < STABLE_CYCLES : nops != 0));
					else if (!go && cmd === ddr_init_pkg::CMD_AUTO_REFRESH_CMD)
					begin
						b += int'(refs == 0 && nops < MRSC_CYCLES);
						refs <= refs + 1;
					end
					else if (!go)
					begin
						b += int'(refs < 8 || nops < 1024);
						go <= 1'b1;
					end
					if (!mset)
					begin
						b += int'(slot - last[mem_ba] < RC_CYCLES);
						last[mem_ba] <= slot;
					end
					b += int'(cmd === ddr_init_pkg::CMD_READ && slot - dll_slot < 1024);
					// Loop off: reads stay illegal until it is on again
					if (mset)
						dll_slot <= mem_addr[7] ? slot : 32'h3FFFFFFF;
				end
			end
			dev_err <= dev_err + b;
		end
	end
endmodule : mem_dev_model

// ---- tb/testbench.sv ----
// Self-checking bench for the memory initialisation controller.
// Assumes the device model flags every non-idle command it decodes.
`timescale 1ns/1ps
module testbench;
	typedef struct packed {logic [2:0] cmd; logic [2:0] ba; logic [19:0] addr;} exp_t;
	logic mclk, sys_rst, dll_reset_req, req_valid, req_ready, init_done;
	logic mem_ck, mem_ck_n, mem_cs_n, mem_we_n, mem_ref_n, ev_valid;
	logic [1:0] req_kind;
	logic [2:0] req_bank, mem_ba;
	logic [19:0] mode_cfg, req_addr, mem_addr, cfg_on;
	logic [25:0] m;
	int errors, samples_checked, cyc, dev_err, t_take, t0, seed;
	exp_t exp_q [$];
	exp_t e;
	always #2.5 mclk = ~mclk;
	ddr_init_ctrl #(.STABLE_CYCLES(10)) dut (.mclk, .sys_rst, .mode_cfg, .dll_reset_req,
		.req_valid, .req_ready, .req_kind, .req_bank, .req_addr, .init_done, .mem_ck,
		.mem_ck_n, .mem_cs_n, .mem_we_n, .mem_ref_n, .mem_addr, .mem_ba);
	mem_dev_model #(.STABLE_CYCLES(10)) model (.mclk, .sys_rst, .mem_ck, .mem_ck_n,
		.cmd({mem_cs_n, mem_we_n, mem_ref_n}), .mem_addr, .mem_ba, .ev_valid, .dev_err);
	////////////////////////////////////////////////////////////////
	task automatic chk_cmd(input logic [25:0] got, input logic [25:0] want);
		samples_checked++;
		if (got !== want)
		begin
			errors++;
			$display("BAD %0t command %h want %h", $time, got, want);
		end
	endtask : chk_cmd
	task automatic chk_flag(input logic [31:0] got, input logic [31:0] want);
		samples_checked++;
		if (got !== want)
		begin
			errors++;
			$display("BAD %0t value %0h want %0h", $time, got, want);
		end
	endtask : chk_flag
	task automatic wrap_up();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	// Leaves the request raised; caller drops it or sends again
	task automatic send(input logic [1:0] k, input logic [2:0] b, input int gap);
		logic [19:0] a;
		logic [2:0] c;
		a = 20'($random(seed));
		c = k == 2'h0 ? ddr_init_pkg::CMD_READ : k == 2'h1 ? ddr_init_pkg::CMD_WRITE
			: ddr_init_pkg::CMD_AUTO_REFRESH_CMD;
		req_valid <= 1'b1;
		req_kind <= k;
		req_bank <= b;
		req_addr <= a;
		do @(negedge mclk); while (req_ready !== 1'b1);
		if (gap > 0)
			chk_flag(32'(cyc - t_take), 32'(gap));
		t_take = cyc;
		exp_q.push_back({c, b, k == 2'h2 ? 20'h0 : a});
		@(posedge mclk);
	endtask : send
	task automatic probe(input logic [1:0] k, input logic [2:0] b);
		req_valid <= 1'b1;
		req_kind <= k;
		req_bank <= b;
		repeat (8)
		begin
			@(negedge mclk);
			chk_flag(32'(req_ready), 32'h0);
		end
		@(posedge mclk);
		req_valid <= 1'b0;
		@(posedge mclk);
	endtask : probe
	////////////////////////////////////////////////////////////////
	always @(negedge mclk)
	begin
		if (ev_valid === 1'b1)
		begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : '1;
			// Idle-address and mode writes ignore the bank; refreshes ignore address
			m = e.cmd === ddr_init_pkg::CMD_MRS ? 26'h38FFFFF
				: e.cmd === ddr_init_pkg::CMD_AUTO_REFRESH_CMD ? 26'h3F00000 : 26'h3FFFFFF;
			chk_cmd({mem_cs_n, mem_we_n, mem_ref_n, mem_ba, mem_addr} & m, e & m);
		end
	end
	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 12000)
		begin
			errors++;
			wrap_up();
		end
	end
	initial
	begin
		seed = 32'hc249f0f5;
		{mclk, sys_rst, dll_reset_req, req_valid} = 4'h4;
		{req_kind, req_bank, req_addr} = '0;
		{errors, samples_checked, cyc, t_take} = '0;
		mode_cfg = 20'($random(seed));
		cfg_on = (mode_cfg & ~ddr_init_pkg::UPPER_MASK) | ddr_init_pkg::DLL_MASK;
		exp_q.push_back({ddr_init_pkg::CMD_MRS, 3'h0, 20'h0});
		exp_q.push_back({ddr_init_pkg::CMD_MRS, 3'h0, 20'h0});
		exp_q.push_back({ddr_init_pkg::CMD_MRS, 3'h0, cfg_on});
		for (int i = 0; i < 8; i++)
			exp_q.push_back({ddr_init_pkg::CMD_AUTO_REFRESH_CMD, 3'(i), 20'h0});
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		probe(2'h1, 3'h0);
		while (init_done !== 1'b1) @(negedge mclk);
		chk_flag(32'(cyc >= 2 * (10 + 3 + 6 + 8 + 1024)), 32'h1);
		@(posedge mclk);
		for (int i = 0; i < 8; i++)
			send(2'(i % 3), 3'(i), i > 0 ? 2 : 0);
		send(2'h2, 3'h5, 0);
		send(2'h1, 3'h5, 2 * ddr_init_pkg::RC_CYCLES);
		send(2'h1, 3'h5, 2 * ddr_init_pkg::RC_CYCLES);
		send(2'h0, 3'h5, 2 * ddr_init_pkg::RC_CYCLES);
		req_valid <= 1'b0;
		@(posedge mclk);
		probe(2'h3, 3'h1);
		@(posedge mclk);
		mode_cfg <= 20'($random(seed));
		dll_reset_req <= 1'b1;
		@(posedge mclk);
		dll_reset_req <= 1'b0;
		t0 = cyc;
		cfg_on = (mode_cfg & ~ddr_init_pkg::UPPER_MASK) | ddr_init_pkg::DLL_MASK;
		exp_q.push_back({ddr_init_pkg::CMD_MRS, 3'h0, cfg_on & ~ddr_init_pkg::DLL_MASK});
		exp_q.push_back({ddr_init_pkg::CMD_MRS, 3'h0, cfg_on});
		probe(2'h0, 3'h2);
		send(2'h0, 3'h2, 0);
		req_valid <= 1'b0;
		chk_flag(32'(t_take - t0 >= 2048), 32'h1);
		while (exp_q.size() != 0) @(posedge mclk);
		chk_flag(32'(dev_err), 32'h0);
		sys_rst <= 1'b1;
		@(negedge mclk);
		chk_flag(32'({init_done, req_ready, mem_cs_n, mem_we_n, mem_ref_n, mem_ck}), 32'hE);
		wrap_up();
	end
endmodule : testbench
